// ===== design/alo_ctrl.v
// Host-facing lock, address-offset and overclock control logic.
// Assumes a framed register port from the bus engine, nonvolatile
// settings held stable, and telemetry/codes on core_clk.
// Operation
// - Offset enable adds strap offset 0..15 to base serial address.
// - Offset added arithmetically; base plus fifteen at maximum.
// - Strap sampled once at enable; pin then only a lock input.
// - With pin protection on, lock pin high unlocks, low locks.
// - Read protection: none, config, all but telemetry, all.
// - Write protection: none, config only, all registers.
// - Unlock by password, pin, pin and password, or never.
// - Stored 16-bit key; zero is not a valid key.
// - Attempt register unlocks when written value matches key.
// - Fourth failed attempt locks up, refusing further unlocks.
// - Writing a key byte relocks password unlock at once; host re-unlocks.
// - Command bit 12 moves target to 9-bit overclock code.
// - Override mode uses overclock code, ignores processor code.
// - Track mode applies processor code changes as offset.
// - Bits 10..9 scale droop 100, 80, 60 or 0 percent.
// - Code step 6.25 or 5 mV; codes up to 366 or 459.
// - Output clamped to 4-bit selected maximum always.
// - Enable low clears overclock mode at once.
// - Input current gets fixed and per-phase trims.
// - Output current trims per loop, 0.5 A and 0.25 A steps.
// - Output voltage offset in 5 or 6.25 mV code steps.
// - Temperature report offset in 1 degree steps.
// - Reported voltage computed from code and load line.
`timescale 1ns/1ns
`include "alo_map.vh"
module alo_ctrl (
   // Clock and reset
   input wire core_clk,
   input wire rst_b,
   // Pins
   input wire en_pin,
   input wire lock_pin,
   input wire [3:0] strap_code,
   // Nonvolatile settings
   input wire [6:0] nv_base_addr,
   input wire nv_offset_en,
   input wire [1:0] nv_rd_level,
   input wire [1:0] nv_wr_level,
   input wire [1:0] nv_unlock_mode,
   input wire nv_pin_prot_en,
   input wire [15:0] nv_key_init,
   input wire nv_step_625,
   input wire [3:0] nv_vmax_sel,
   input wire [3:0] nv_vout_trim,
   input wire [7:0] nv_iin_fixed_trim,
   input wire [7:0] nv_iin_phase_trim,
   input wire [4:0] nv_iout1_trim,
   input wire [4:0] nv_iout2_trim,
   input wire [7:0] nv_temp_trim,
   // Register port
   input wire reg_wr_en,
   input wire reg_rd_en,
   input wire [7:0] reg_addr,
   input wire [1:0] reg_cls,
   input wire [7:0] reg_wdata,
   output reg [7:0] reg_rdata,
   output reg reg_denied,
   output wire acc_rd_ok,
   output wire acc_wr_ok,
   // Key store
   output reg nv_key_wr,
   output reg [15:0] nv_key_data,
   // Processor code and telemetry
   input wire [8:0] cpu_code,
   input wire [15:0] droop_q,
   input wire [15:0] iin_raw,
   input wire [3:0] phases,
   input wire [15:0] iout1_raw,
   input wire [15:0] iout2_raw,
   input wire [7:0] temp_raw,
   // Results
   output reg [6:0] bus_addr,
   output wire unlocked,
   output wire oc_active,
   output reg [8:0] vout_code,
   output reg [2:0] ll_fifths,
   output reg [15:0] vout_rpt,
   output reg [15:0] iin_rpt,
   output reg [15:0] iout1_rpt,
   output reg [15:0] iout2_rpt,
   output reg [7:0] temp_rpt
);
   wire en_s;
   wire lock_s;
   reg en_q;
   reg [3:0] strap_q;
   reg [15:0] key_q;
   reg [15:0] try_q;
   reg pw_ok_q;
   reg [2:0] fails_q;
   reg lockup_q;
   reg [15:0] oc_q;
   reg [8:0] base_cpu_q;
   reg [1:0] cls_sel;
   reg gate_ok;
   reg [11:0] target;
   reg [11:0] limit;
   reg [7:0] rd_mux;
   wire rd_ok;
   wire wr_ok;
   wire wr_go;
   wire [15:0] key_new;
   wire [15:0] try_word;
   wire [2:0] fails_d;
   wire pin_hi;
   wire [8:0] vmax_code;
   wire [11:0] code_max;
   wire [4:0] step_q;
   wire signed [12:0] track_delta;
   wire signed [12:0] raw_target;
   wire [18:0] droop_scaled;
   wire signed [17:0] vout_sum;
   wire signed [17:0] iin_sum;
   wire signed [17:0] iout1_sum;
   wire signed [17:0] iout2_sum;
   wire signed [8:0] temp_sum;

   alo_pin_sync u_en_sync (
      .core_clk(core_clk),
      .rst_b(rst_b),
      .pin(en_pin),
      .level_q(en_s)
   );

   alo_pin_sync u_lock_sync (
      .core_clk(core_clk),
      .rst_b(rst_b),
      .pin(lock_pin),
      .level_q(lock_s)
   );

   // Read gate per protection level
   function prot_rd;
      input [1:0] lvl;
      input [1:0] cls;
      begin
         if (cls == `ALO_CLS_OPEN || lvl == `ALO_RD_NONE)
            prot_rd = 1'b0;
         else if (lvl == `ALO_RD_CFG)
            prot_rd = (cls == `ALO_CLS_CFG);
         else if (lvl == `ALO_RD_NOTEL)
            prot_rd = (cls != `ALO_CLS_TELEM);
         else
            prot_rd = 1'b1;
      end
   endfunction

   // Write gate per protection level
   function prot_wr;
      input [1:0] lvl;
      input [1:0] cls;
      begin
         if (cls == `ALO_CLS_OPEN || lvl == `ALO_WR_NONE)
            prot_wr = 1'b0;
         else if (lvl == `ALO_WR_CFG)
            prot_wr = (cls == `ALO_CLS_CFG);
         else
            prot_wr = 1'b1;
      end
   endfunction

   // Pin counts as high when pin protection is off
   assign pin_hi = ~nv_pin_prot_en | lock_s;

   always @*
   begin
      case (nv_unlock_mode)
         `ALO_UL_PW: gate_ok = pw_ok_q;
         `ALO_UL_PIN: gate_ok = pin_hi;
         `ALO_UL_BOTH: gate_ok = pw_ok_q & pin_hi;
         default: gate_ok = 1'b0;
      endcase
   end

   // Lockup overrides every unlock path
   assign unlocked = gate_ok & ~lockup_q;

   // Own registers carry fixed classes
   always @*
   begin
      case (reg_addr)
         `ALO_A_KEY_LO, `ALO_A_KEY_HI: cls_sel = `ALO_CLS_CFG;
         `ALO_A_TRY_LO, `ALO_A_TRY_HI,
         `ALO_A_STAT: cls_sel = `ALO_CLS_OPEN;
         `ALO_A_VOUT_LO, `ALO_A_VOUT_HI: cls_sel = `ALO_CLS_TELEM;
         `ALO_A_OC_LO, `ALO_A_OC_HI: cls_sel = `ALO_CLS_OTHER;
         default: cls_sel = reg_cls;
      endcase
   end

   assign rd_ok = ~prot_rd(nv_rd_level, cls_sel) | unlocked;
   assign wr_ok = ~prot_wr(nv_wr_level, cls_sel) | unlocked;
   assign acc_rd_ok = rd_ok;
   assign acc_wr_ok = wr_ok;
   assign wr_go = reg_wr_en & wr_ok;

   assign key_new = (reg_addr == `ALO_A_KEY_HI) ?
      {reg_wdata, key_q[7:0]} : {key_q[15:8], reg_wdata};
   assign try_word = {try_q[15:8], reg_wdata};
   assign fails_d = fails_q + 3'h1;

   // Enable edge, strap capture, serial address
   always @(posedge core_clk)
   begin
      if (!rst_b)
      begin
         en_q <= 1'b0;
         strap_q <= 4'h0;
         bus_addr <= 7'h00;
      end
      else
      begin
         en_q <= en_s;
         if (en_s && !en_q)
            strap_q <= strap_code;
         bus_addr <= nv_base_addr +
            (nv_offset_en ? {3'h0, strap_q} : 7'h00);
      end
   end

   // Key, attempts and lockup
   always @(posedge core_clk)
   begin
      if (!rst_b)
      begin
         key_q <= nv_key_init;
         try_q <= 16'h0000;
         pw_ok_q <= 1'b0;
         fails_q <= 3'h0;
         lockup_q <= 1'b0;
         nv_key_wr <= 1'b0;
         nv_key_data <= 16'h0000;
      end
      else
      begin
         nv_key_wr <= 1'b0;
         if (wr_go && (reg_addr == `ALO_A_KEY_LO ||
             reg_addr == `ALO_A_KEY_HI))
         begin
            // Zero key refused, but the relock still happens
            if (key_new != `ALO_KEY_ZERO)
            begin
               key_q <= key_new;
               nv_key_wr <= 1'b1;
               nv_key_data <= key_new;
            end
            pw_ok_q <= 1'b0;
         end
         if (wr_go && reg_addr == `ALO_A_TRY_HI)
            try_q[15:8] <= reg_wdata;
         if (wr_go && reg_addr == `ALO_A_TRY_LO)
         begin
            try_q[7:0] <= reg_wdata;
            if (!lockup_q)
            begin
               if (try_word == key_q && key_q != `ALO_KEY_ZERO)
               begin
                  pw_ok_q <= 1'b1;
                  fails_q <= 3'h0;
               end
               else
               begin
                  pw_ok_q <= 1'b0;
                  fails_q <= fails_d;
                  if (fails_d == `ALO_MAX_FAILS)
                     lockup_q <= 1'b1;
               end
            end
         end
         // Enable cycle is the only way out of lockup
         if (!en_s)
         begin
            lockup_q <= 1'b0;
            fails_q <= 3'h0;
            pw_ok_q <= 1'b0;
         end
      end
   end

   // Overclock command register
   always @(posedge core_clk)
   begin
      if (!rst_b)
      begin
         oc_q <= `ALO_OC_RESET;
         base_cpu_q <= 9'h000;
      end
      else
      begin
         if (wr_go && reg_addr == `ALO_A_OC_LO)
         begin
            oc_q[7:0] <= reg_wdata;
            base_cpu_q <= cpu_code;
         end
         if (wr_go && reg_addr == `ALO_A_OC_HI)
         begin
            oc_q[15:8] <= reg_wdata;
            base_cpu_q <= cpu_code;
         end
         // Restart must boot at the normal code
         if (!en_s)
            oc_q[`ALO_OC_EN] <= 1'b0;
      end
   end

   assign oc_active = oc_q[`ALO_OC_EN];

   assign step_q = nv_step_625 ? `ALO_STEP_625 : `ALO_STEP_500;
   assign code_max = nv_step_625 ? `ALO_CODE_MAX_625 :
      `ALO_CODE_MAX_500;
   assign vmax_code = nv_step_625 ?
      `ALO_VMAX_BASE_625 + {5'h00, nv_vmax_sel} * `ALO_VMAX_STEP_625 :
      `ALO_VMAX_BASE_500 + {5'h00, nv_vmax_sel} * `ALO_VMAX_STEP_500;

   assign track_delta = $signed({4'h0, cpu_code}) -
      $signed({4'h0, base_cpu_q});
   assign raw_target = !oc_active ? $signed({4'h0, cpu_code}) :
      oc_q[`ALO_OC_OVR] ?
      $signed({4'h0, oc_q[`ALO_OC_CODE_HI:0]}) :
      $signed({4'h0, oc_q[`ALO_OC_CODE_HI:0]}) + track_delta;

   // Trim is signed; positive field lowers the target
   always @*
   begin
      target = raw_target[11:0] -
         {{8{nv_vout_trim[3]}}, nv_vout_trim};
      limit = ({3'h0, vmax_code} < code_max) ?
         {3'h0, vmax_code} : code_max;
      if (target[11])
         target = 12'h000;
      else if (target > limit)
         target = limit;
   end

   always @(posedge core_clk)
   begin
      if (!rst_b)
         ll_fifths <= `ALO_LL_100;
      else
      begin
         case (oc_q[`ALO_OC_LL_HI:`ALO_OC_LL_LO])
            2'h0: ll_fifths <= `ALO_LL_100;
            2'h1: ll_fifths <= `ALO_LL_80;
            2'h2: ll_fifths <= `ALO_LL_60;
            default: ll_fifths <= `ALO_LL_0;
         endcase
      end
   end

   // Droop scaling only applies in overclock mode
   assign droop_scaled = oc_active ?
      ({3'h0, droop_q} * {16'h0000, ll_fifths}) / `ALO_LL_DIV :
      {3'h0, droop_q};
   assign vout_sum = $signed({8'h00, ({1'b0, vout_code} + 10'h001)} *
      {13'h0000, step_q}) - $signed({1'b0, droop_scaled[16:0]});
   assign iin_sum = $signed({2'h0, iin_raw}) +
      ($signed({{10{nv_iin_fixed_trim[7]}}, nv_iin_fixed_trim})
      <<< `ALO_IIN_FIX_SH) +
      $signed({{10{nv_iin_phase_trim[7]}}, nv_iin_phase_trim}) *
      $signed({14'h0000, phases});
   assign iout1_sum = $signed({2'h0, iout1_raw}) +
      ($signed({{13{nv_iout1_trim[4]}}, nv_iout1_trim})
      <<< `ALO_IOUT1_SH);
   assign iout2_sum = $signed({2'h0, iout2_raw}) +
      $signed({{13{nv_iout2_trim[4]}}, nv_iout2_trim});
   assign temp_sum = $signed({temp_raw[7], temp_raw}) +
      $signed({nv_temp_trim[7], nv_temp_trim});

   // Output code and reports
   always @(posedge core_clk)
   begin
      if (!rst_b)
      begin
         vout_code <= 9'h000;
         vout_rpt <= 16'h0000;
         iin_rpt <= 16'h0000;
         iout1_rpt <= 16'h0000;
         iout2_rpt <= 16'h0000;
         temp_rpt <= 8'h00;
      end
      else
      begin
         vout_code <= target[8:0];
         vout_rpt <= vout_sum[17] ? 16'h0000 : vout_sum[15:0];
         iin_rpt <= iin_sum[15:0];
         iout1_rpt <= iout1_sum[15:0];
         iout2_rpt <= iout2_sum[15:0];
         temp_rpt <= temp_sum[7:0];
      end
   end

   // Key reads back through protection, attempt reads freely
   always @*
   begin
      case (reg_addr)
         `ALO_A_KEY_LO: rd_mux = key_q[7:0];
         `ALO_A_KEY_HI: rd_mux = key_q[15:8];
         `ALO_A_TRY_LO: rd_mux = try_q[7:0];
         `ALO_A_TRY_HI: rd_mux = try_q[15:8];
         `ALO_A_OC_LO: rd_mux = oc_q[7:0];
         `ALO_A_OC_HI: rd_mux = oc_q[15:8];
         `ALO_A_STAT: rd_mux = {lockup_q, unlocked, pin_hi,
            oc_active, strap_q};
         `ALO_A_VOUT_LO: rd_mux = vout_rpt[7:0];
         `ALO_A_VOUT_HI: rd_mux = vout_rpt[15:8];
         default: rd_mux = 8'h00;
      endcase
   end

   always @(posedge core_clk)
   begin
      if (!rst_b)
      begin
         reg_rdata <= 8'h00;
         reg_denied <= 1'b0;
      end
      else
      begin
         reg_denied <= (reg_rd_en & ~rd_ok) | (reg_wr_en & ~wr_ok);
         if (reg_rd_en)
            reg_rdata <= rd_ok ? rd_mux : 8'h00;
      end
   end
endmodule

// ===== design/alo_map.vh
// Constants for the access lock and overclock controller.
// Included by the controller, its checker and its bench; definitions only.
`ifndef ALO_MAP_VH
`define ALO_MAP_VH

// Register port addresses
`define ALO_A_KEY_LO 8'hD0
`define ALO_A_KEY_HI 8'hD1
`define ALO_A_TRY_LO 8'hD2
`define ALO_A_TRY_HI 8'hD3
`define ALO_A_OC_LO 8'hD4
`define ALO_A_OC_HI 8'hD5
`define ALO_A_STAT 8'hD6
`define ALO_A_VOUT_LO 8'hD7
`define ALO_A_VOUT_HI 8'hD8

// Access classes
`define ALO_CLS_OTHER 2'h0
`define ALO_CLS_CFG 2'h1
`define ALO_CLS_TELEM 2'h2
`define ALO_CLS_OPEN 2'h3

// Read protection levels
`define ALO_RD_NONE 2'h0
`define ALO_RD_CFG 2'h1
`define ALO_RD_NOTEL 2'h2

// Write protection levels
`define ALO_WR_NONE 2'h0
`define ALO_WR_CFG 2'h1

// Unlock methods
`define ALO_UL_PW 2'h0
`define ALO_UL_PIN 2'h1
`define ALO_UL_BOTH 2'h2

// Password handling
`define ALO_MAX_FAILS 3'h4
`define ALO_KEY_ZERO 16'h0000

// Overclock command fields
`define ALO_OC_EN 12
`define ALO_OC_OVR 11
`define ALO_OC_LL_HI 10
`define ALO_OC_LL_LO 9
`define ALO_OC_CODE_HI 8
`define ALO_OC_RESET 16'h2000

// Load line scale in fifths of nominal
`define ALO_LL_100 3'h5
`define ALO_LL_80 3'h4
`define ALO_LL_60 3'h3
`define ALO_LL_0 3'h0
`define ALO_LL_DIV 19'h00005

// Voltage steps in 0.25 mV units, code range, clamp table
`define ALO_STEP_625 5'h19
`define ALO_STEP_500 5'h14
`define ALO_CODE_MAX_625 12'h16E
`define ALO_CODE_MAX_500 12'h1CB
`define ALO_VMAX_BASE_625 9'h07F
`define ALO_VMAX_STEP_625 9'h012
`define ALO_VMAX_BASE_500 9'h080
`define ALO_VMAX_STEP_500 9'h018

// Telemetry trim scaling (shift to report units)
`define ALO_IIN_FIX_SH 2
`define ALO_IOUT1_SH 1

`endif

// ===== design/alo_pin_sync.v
// Three-stage synchroniser for one level arriving from a pin.
// Assumes the pin is asynchronous to core_clk.
`timescale 1ns/1ns
module alo_pin_sync (
   // Clock and reset
   input wire core_clk,
   input wire rst_b,
   // Pin and clean level
   input wire pin,
   output reg level_q
);
   reg s1_q;
   reg s2_q;
   reg s3_q;

   // A change counts only once stages two and three agree
   always @(posedge core_clk)
   begin
      if (!rst_b)
      begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         s3_q <= 1'b0;
         level_q <= 1'b0;
      end
      else
      begin
         s1_q <= pin;
         s2_q <= s1_q;
         s3_q <= s2_q;
         if (s2_q == s3_q)
            level_q <= s3_q;
      end
   end
endmodule

// ===== verification/alo_ctrl_chk.sv
// Port checker for the lock and overclock controller.
// Assumes one clock domain and the register port of alo_ctrl.
`timescale 1ns/1ns
`include "alo_map.vh"
module alo_ctrl_chk (
   // Clock and reset
   input wire core_clk,
   input wire rst_b,
   // Pins and settings
   input wire en_pin,
   input wire lock_pin,
   input wire [1:0] nv_unlock_mode,
   input wire nv_pin_prot_en,
   input wire nv_step_625,
   input wire [3:0] nv_vmax_sel,
   // Register port
   input wire reg_wr_en,
   input wire reg_rd_en,
   input wire [7:0] reg_addr,
   input wire [7:0] reg_rdata,
   input wire reg_denied,
   input wire acc_rd_ok,
   input wire acc_wr_ok,
   // Results
   input wire unlocked,
   input wire oc_active,
   input wire [8:0] vout_code,
   // Key store
   input wire nv_key_wr,
   input wire [15:0] nv_key_data
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_b);
   // Clamp limit for the selected index
   function [8:0] vmax(input s, input [3:0] n);
   begin
      vmax = s ? `ALO_VMAX_BASE_625 + `ALO_VMAX_STEP_625 * n
         : `ALO_VMAX_BASE_500 + `ALO_VMAX_STEP_500 * n;
   end
   endfunction
   deny_zero_a: assert property (reg_rd_en ##1 reg_denied |->
      reg_rdata == 8'h00) else $error("denied read gave data");
   deny_cause_a: assert property (reg_denied |->
      $past(reg_rd_en && !acc_rd_ok || reg_wr_en && !acc_wr_ok))
      else $error("denial without refused access");
   key_relock_a: assert property (nv_unlock_mode == `ALO_UL_PW &&
      reg_wr_en && (reg_addr == `ALO_A_KEY_LO || reg_addr == `ALO_A_KEY_HI)
      |=> !unlocked) else $error("key write left port unlocked");
   unlock_cause_a: assert property ($rose(unlocked) &&
      nv_unlock_mode == `ALO_UL_PW && $stable(nv_unlock_mode) |->
      $past(reg_wr_en && reg_addr == `ALO_A_TRY_LO))
      else $error("unlock without attempt write");
   oc_cause_a: assert property ($rose(oc_active) |->
      $past(reg_wr_en && reg_addr == `ALO_A_OC_HI))
      else $error("overclock without command write");
   oc_clear_a: assert property (!en_pin [*6] |-> !oc_active)
      else $error("overclock kept with enable low");
   vout_clamp_a: assert property ($stable(nv_vmax_sel) &&
      $stable(nv_step_625) |-> vout_code <= vmax(nv_step_625, nv_vmax_sel))
      else $error("output above clamp");
   pin_lock_a: assert property (nv_unlock_mode == `ALO_UL_PIN &&
      nv_pin_prot_en && !lock_pin [*6] |-> !unlocked)
      else $error("unlocked with lock pin low");
   never_lock_a: assert property (nv_unlock_mode == 2'h3 |->
      !unlocked) else $error("unlocked in permanent lock");
   key_store_a: assert property (nv_key_wr |->
      nv_key_data != `ALO_KEY_ZERO && $past(reg_wr_en && acc_wr_ok &&
      (reg_addr == `ALO_A_KEY_LO || reg_addr == `ALO_A_KEY_HI)))
      else $error("key stored without granted key write");
   cover property ($rose(unlocked));
   cover property (reg_denied);
   cover property ($rose(oc_active));
endmodule

bind alo_ctrl alo_ctrl_chk chk_u (.core_clk, .rst_b, .en_pin, .lock_pin,
   .nv_unlock_mode, .nv_pin_prot_en, .nv_step_625, .nv_vmax_sel,
   .reg_wr_en, .reg_rd_en, .reg_addr, .reg_rdata, .reg_denied,
   .acc_rd_ok, .acc_wr_ok, .unlocked, .oc_active, .vout_code, .nv_key_wr,
   .nv_key_data);

// ===== verification/alo_host.sv
// Host model driving the register port one byte access at a time.
// Assumes answers land one edge after the access is taken.
`timescale 1ns/1ns
module alo_host (
   // Clock
   input wire core_clk,
   // Register port
   output reg reg_wr_en = 1'b0,
   output reg reg_rd_en = 1'b0,
   output reg [7:0] reg_addr = 8'h00,
   output reg [1:0] reg_cls = 2'h0,
   output reg [7:0] reg_wdata = 8'h00,
   input wire [7:0] reg_rdata,
   input wire reg_denied
);
   // Present, taken next edge, answer sampled one edge later
   task acc(input wr, input [7:0] a, input [1:0] c, input [7:0] d,
      output [7:0] q, output den);
   begin
      @(posedge core_clk);
      reg_wr_en <= wr;
      reg_rd_en <= !wr;
      reg_addr <= a;
      reg_cls <= c;
      reg_wdata <= d;
      @(posedge core_clk);
      reg_wr_en <= 1'b0;
      reg_rd_en <= 1'b0;
      // Released lines never show the last value
      reg_addr <= ~a;
      reg_wdata <= ~d;
      @(posedge core_clk);
      q = reg_rdata;
      den = reg_denied;
   end
   endtask
   // High byte first; the low byte completes the pair
   task w16(input [7:0] a_hi, input [15:0] v);
      reg [7:0] q;
      reg den;
   begin
      acc(1'b1, a_hi, 2'h0, v[15:8], q, den);
      acc(1'b1, a_hi - 8'h01, 2'h0, v[7:0], q, den);
   end
   endtask
   // Command with reserved top bits always 001
   task oc_cmd(input [12:0] f);
   begin
      w16(8'hD5, {3'b001, f});
   end
   endtask
endmodule

// ===== verification/alo_ctrl_test.sv
// Self-checking bench for the lock and overclock controller.
// Assumes alo_host on the register port; settings held by the bench.
`timescale 1ns/1ns
`include "alo_map.vh"
module alo_ctrl_test;
   reg core_clk = 1'b0, rst_b = 1'b0, en_pin = 1'b0, lock_pin = 1'b0;
   reg nv_offset_en = 1'b1, nv_pin_prot_en = 1'b1, nv_step_625 = 1'b1;
   reg [3:0] strap_code = 4'hF, nv_vmax_sel = 4'hF, nv_vout_trim = 4'h0;
   reg [3:0] phases = 4'h4;
   reg [6:0] nv_base_addr = 7'h28;
   reg [1:0] nv_rd_level = 2'h3, nv_wr_level = 2'h2, nv_unlock_mode = 2'h0;
   reg [15:0] nv_key_init = 16'hA5C3, droop_q = 16'h0064;
   reg [15:0] iin_raw = 16'h0100, iout1_raw = 16'h0040;
   reg [15:0] iout2_raw = 16'h0040;
   reg [7:0] nv_iin_fixed_trim = 8'h02, nv_iin_phase_trim = 8'h03;
   reg [7:0] nv_temp_trim = 8'hFE, temp_raw = 8'h32, q;
   reg [4:0] nv_iout1_trim = 5'h1F, nv_iout2_trim = 5'h03;
   reg [8:0] cpu_code = 9'h080;
   reg [2:0] e;
   reg den;
   integer err_count = 0, check_count = 0, i;
   wire reg_wr_en, reg_rd_en, reg_denied, acc_rd_ok, acc_wr_ok, nv_key_wr;
   wire unlocked, oc_active;
   wire [7:0] reg_addr, reg_wdata, reg_rdata, temp_rpt;
   wire [1:0] reg_cls;
   wire [15:0] nv_key_data, vout_rpt, iin_rpt, iout1_rpt, iout2_rpt;
   wire [6:0] bus_addr;
   wire [8:0] vout_code;
   wire [2:0] ll_fifths;
   always #5 core_clk = ~core_clk;
   alo_ctrl dut_u (.core_clk, .rst_b, .en_pin, .lock_pin, .strap_code,
      .nv_base_addr, .nv_offset_en, .nv_rd_level, .nv_wr_level,
      .nv_unlock_mode, .nv_pin_prot_en, .nv_key_init, .nv_step_625,
      .nv_vmax_sel, .nv_vout_trim, .nv_iin_fixed_trim, .nv_iin_phase_trim,
      .nv_iout1_trim, .nv_iout2_trim, .nv_temp_trim, .reg_wr_en,
      .reg_rd_en, .reg_addr, .reg_cls, .reg_wdata, .reg_rdata, .reg_denied,
      .acc_rd_ok, .acc_wr_ok, .nv_key_wr, .nv_key_data, .cpu_code, .droop_q,
      .iin_raw, .phases, .iout1_raw, .iout2_raw, .temp_raw, .bus_addr,
      .unlocked, .oc_active, .vout_code, .ll_fifths, .vout_rpt, .iin_rpt,
      .iout1_rpt, .iout2_rpt, .temp_rpt);
   alo_host host_u (.core_clk, .reg_wr_en, .reg_rd_en, .reg_addr, .reg_cls,
      .reg_wdata, .reg_rdata, .reg_denied);
   task check(input [15:0] seen, input [15:0] exp);
   begin
      check_count = check_count + 1;
      if (seen !== exp)
      begin
         err_count = err_count + 1;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   end
   endtask
   task tick(input integer n);
      repeat (n) @(posedge core_clk);
   endtask
   // Enable low long enough to pass the pin synchroniser
   task en_cycle;
   begin
      en_pin <= 1'b0;
      tick(8);
      en_pin <= 1'b1;
      tick(8);
   end
   endtask
   task try_key(input [15:0] k);
      host_u.w16(`ALO_A_TRY_HI, k);
   endtask
   task t_addr;
   begin
      check(bus_addr, 7'h37);
      strap_code <= 4'h0;
      tick(8);
      check(bus_addr, 7'h37);
      host_u.acc(1'b0, `ALO_A_STAT, 2'h0, 8'h00, q, den);
      check(q[3:0], 4'hF);
      nv_offset_en <= 1'b0;
      en_cycle;
      check(bus_addr, 7'h28);
      nv_offset_en <= 1'b1;
      strap_code <= 4'hF;
      en_cycle;
      $display("test address done");
   end
   endtask
   task t_pass;
   begin
      host_u.acc(1'b0, 8'h40, `ALO_CLS_CFG, 8'h00, q, den);
      check(den, 1'b1);
      for (i = 0; i < 3; i = i + 1)
         try_key(16'h1234);
      try_key(16'hA5C3);
      check(unlocked, 1'b1);
      host_u.acc(1'b1, `ALO_A_KEY_HI, 2'h0, 8'h5A, q, den);
      check(nv_key_data, 16'h5AC3);
      check(unlocked, 1'b0);
      try_key(16'h5AC3);
      check(unlocked, 1'b1);
      host_u.acc(1'b1, `ALO_A_KEY_LO, 2'h0, 8'h11, q, den);
      check(unlocked, 1'b0);
      try_key(16'h5A11);
      check(unlocked, 1'b1);
      host_u.acc(1'b1, `ALO_A_KEY_HI, 2'h0, 8'h00, q, den);
      try_key(16'h0011);
      host_u.acc(1'b1, `ALO_A_KEY_LO, 2'h0, 8'h00, q, den);
      check(nv_key_data, 16'h0011);
      try_key(16'h0000);
      check(unlocked, 1'b0);
      try_key(16'h0011);
      check(unlocked, 1'b1);
      host_u.acc(1'b0, `ALO_A_TRY_LO, 2'h0, 8'h00, q, den);
      check(q, 8'h11);
      $display("test password done");
   end
   endtask
   task t_lockup;
   begin
      en_cycle;
      for (i = 0; i < 4; i = i + 1)
         try_key(16'h1234);
      try_key(16'h0011);
      check(unlocked, 1'b0);
      tick(50);
      try_key(16'h0011);
      host_u.acc(1'b0, `ALO_A_STAT, 2'h0, 8'h00, q, den);
      check(q[7:6], 2'h2);
      en_cycle;
      try_key(16'h0011);
      check(unlocked, 1'b1);
      $display("test lockup done");
   end
   endtask
   task t_pin;
   begin
      en_cycle;
      nv_unlock_mode <= `ALO_UL_PIN;
      lock_pin <= 1'b0;
      tick(8);
      check(unlocked, 1'b0);
      lock_pin <= 1'b1;
      tick(8);
      host_u.acc(1'b0, 8'h40, `ALO_CLS_CFG, 8'h00, q, den);
      check(den, 1'b0);
      nv_pin_prot_en <= 1'b0;
      lock_pin <= 1'b0;
      tick(8);
      check(unlocked, 1'b1);
      nv_pin_prot_en <= 1'b1;
      nv_unlock_mode <= `ALO_UL_BOTH;
      lock_pin <= 1'b1;
      tick(8);
      check(unlocked, 1'b0);
      try_key(16'h0011);
      check(unlocked, 1'b1);
      lock_pin <= 1'b0;
      tick(8);
      check(unlocked, 1'b0);
      nv_unlock_mode <= 2'h3;
      lock_pin <= 1'b1;
      try_key(16'h0011);
      check(unlocked, 1'b0);
      $display("test pin done");
   end
   endtask
   // Locked for good; sweep level against class on a foreign address
   task t_prot;
   begin
      for (i = 0; i < 16; i = i + 1)
      begin
         nv_rd_level <= i[3:2];
         nv_wr_level <= i[3:2];
         host_u.acc(1'b0, 8'h40, i[1:0], 8'h00, q, den);
         check(den, (16'h7320 >> i) & 16'h0001);
         host_u.acc(1'b1, 8'h40, i[1:0], 8'h00, q, den);
         check(den, (16'h7720 >> i) & 16'h0001);
      end
      $display("test protection done");
   end
   endtask
   task t_oc;
   begin
      nv_unlock_mode <= `ALO_UL_PW;
      nv_rd_level <= `ALO_RD_NONE;
      nv_wr_level <= `ALO_WR_NONE;
      host_u.oc_cmd({4'hC, 9'h100});
      tick(3);
      check(oc_active, 1'b1);
      check(vout_code, 9'h100);
      cpu_code <= 9'h090;
      tick(3);
      check(vout_code, 9'h100);
      for (i = 0; i < 4; i = i + 1)
      begin
         e = (i == 3) ? 3'h0 : 3'h5 - i[2:0];
         host_u.oc_cmd({2'h3, i[1:0], 9'h100});
         tick(3);
         check(ll_fifths, e);
         check(vout_rpt, 16'h1919 - 16'h0014 * e);
      end
      host_u.oc_cmd({4'h8, 9'h100});
      cpu_code <= 9'h094;
      tick(3);
      check(vout_code, 9'h104);
      nv_vmax_sel <= 4'h0;
      tick(3);
      check(vout_code, 9'h07F);
      nv_step_625 <= 1'b0;
      tick(3);
      check(vout_code, 9'h080);
      check(vout_rpt, 16'h09B0);
      nv_step_625 <= 1'b1;
      nv_vmax_sel <= 4'hF;
      en_pin <= 1'b0;
      tick(8);
      check(oc_active, 1'b0);
      en_pin <= 1'b1;
      tick(8);
      check(vout_code, 9'h094);
      $display("test overclock done");
   end
   endtask
   task t_telem;
   begin
      nv_vout_trim <= 4'hF;
      cpu_code <= 9'h080;
      tick(3);
      check(vout_code, 9'h081);
      check(vout_rpt, 16'h0C4E);
      check(iin_rpt, 16'h0114);
      check(iout1_rpt, 16'h003E);
      check(iout2_rpt, 16'h0043);
      check(temp_rpt, 8'h30);
      $display("test telemetry done");
   end
   endtask
   task report_and_stop;
   begin
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   end
   endtask
   initial
   begin
      tick(20);
      rst_b <= 1'b1;
      tick(2);
      en_pin <= 1'b1;
      tick(8);
      t_addr;
      t_pass;
      t_lockup;
      t_pin;
      t_prot;
      t_oc;
      t_telem;
      report_and_stop;
   end
   // Hang guard
   initial
   begin
      tick(20000);
      err_count = err_count + 1;
      report_and_stop;
   end
endmodule
